// ===== rtl/sbsc_cycle_ctrl.sv
// Purpose: cycle decode, burst control, byte writes and data pin control
// Assumes: all inputs except out_enable_n synchronous to ref_clk
// Notes: data enables follow out_enable_n without a register, by design
`timescale 1ns/100ps

// Functional notes
// - sleep high: power down, float data, ignore every other input
// - all selects active and processor strobe low: read burst at external address
// - selected, controller strobe low, processor high: begin burst, write per decode
// - no strobe and step low: go to next burst address, read or write
// - no strobe and step high: stay on current address, repeat access
// - pipelined select high makes processor strobe don't-care; continue still works
// - write decode low on global write, or byte enable with any lane low
// - each low byte select writes its lane and parity; none selected reads
// - never write on the processor strobe start cycle
// - output enable masked during writes, drivers stay off
// - reads drive all bits when output enable low, else float
// - data direction follows cycle type and output enable combinationally
// - two-bit wrapping counter, linear when order low, interleaved when high
// - controller strobe ignored while processor strobe is low and pipelined select active
// - sleep entry and exit take two cycles; master stays deselected meanwhile
module sbsc_cycle_ctrl
  import sbsc_pkg::*;
#(
  parameter int ADDR_W = SBSC_ADDR_W,
  parameter int LANES = SBSC_LANES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // selects and sleep
  input wire logic chip_sel_pipe_n,
  input wire logic chip_sel_hi,
  input wire logic chip_sel_lo_n,
  input wire logic sleep_request,
  // burst control
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_step_n,
  input wire logic burst_order,
  input wire logic [ADDR_W-1:0] addr,
  // write control
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic [LANES-1:0] byte_select_n,
  input wire logic out_enable_n,
  // data and parity pins
  input wire logic [LANES*SBSC_LANE_W-1:0] dq_in,
  output logic [LANES*SBSC_LANE_W-1:0] dq_out,
  output logic [LANES*SBSC_LANE_W-1:0] dq_oe,
  input wire logic [LANES-1:0] parity_io_in,
  output logic [LANES-1:0] parity_io_out,
  output logic [LANES-1:0] parity_io_oe,
  // status
  output logic power_down
);
  localparam int DW = LANES * SBSC_LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  // refused at elaboration: the pin model and the address split need these ranges
  if (ADDR_W < 3 || ADDR_W > 24 || (LANES != 2 && LANES != 4)) begin : g_bad_cfg
    $error("sbsc_cycle_ctrl: unsupported ADDR_W or LANES");
  end

  sbsc_state_t state;
  sbsc_state_t next_state;
  logic [1:0] sleep_cnt;
  logic [1:0] next_sleep_cnt;
  logic [ADDR_W-3:0] hi_addr;
  logic active;
  logic cyc_read;
  logic [LANES-1:0] lane_wr;
  logic [DW-1:0] rd_data;
  logic [LANES-1:0] rd_par;

  sbsc_burst_if burst ();

  sbsc_burst_ctr u_ctr (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .bus(burst)
  );

  // cycle decode
  wire run = (state == SBSC_ST_RUN) && !sleep_request;
  wire sel_all = !chip_sel_pipe_n && chip_sel_hi && !chip_sel_lo_n;
  // processor strobe only counts with the pipelined select active
  wire proc_go = !chip_sel_pipe_n && !proc_addr_strobe_n;
  wire start = proc_go || !ctrl_addr_strobe_n;
  wire do_begin = run && start && sel_all;
  wire do_desel = run && start && !sel_all;
  wire do_cont = run && !start && active;
  wire write_dec_n = global_write_n && (byte_write_enable_n || &byte_select_n);
  // processor start is always a read; controller strobe is ignored then
  wire begin_wr = do_begin && !proc_go && !write_dec_n;
  wire cont_wr = do_cont && !write_dec_n;
  wire do_write = begin_wr || cont_wr;
  wire do_read = (do_begin && !begin_wr) || (do_cont && write_dec_n);
  wire stepping = do_cont && !burst_step_n;
  wire [1:0] low_addr = stepping ? burst.next_addr : burst.cur_addr;
  wire [ADDR_W-1:0] acc_addr = do_begin ? addr : {hi_addr, low_addr};

  assign burst.load = do_begin;
  assign burst.step = stepping;
  assign burst.interleave = burst_order;
  assign burst.base_addr = addr[1:0];

  // output enable is asynchronous: no register between it and the pins
  wire drive = cyc_read && !out_enable_n && !sleep_request;
  assign dq_oe = {DW{drive}};
  assign parity_io_oe = {LANES{drive}};

  // per-lane storage, so each lane has its own write port
  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++) begin : g_lane
      logic [SBSC_LANE_W:0] lane_mem [DEPTH];
      assign lane_wr[gi] = !global_write_n || (!byte_write_enable_n && !byte_select_n[gi]);
      always_ff @(posedge ref_clk) begin
        if (do_write && lane_wr[gi]) begin
          lane_mem[acc_addr] <= {parity_io_in[gi], dq_in[gi*SBSC_LANE_W +: SBSC_LANE_W]};
        end
      end
      always_ff @(posedge ref_clk) begin
        if (do_read) begin
          {rd_par[gi], rd_data[gi*SBSC_LANE_W +: SBSC_LANE_W]} <= lane_mem[acc_addr];
        end
      end
    end
  endgenerate

  assign dq_out = rd_data;
  assign parity_io_out = rd_par;

  // sleep sequencing: entry and exit each take the documented count
  always_comb begin
    next_state = state;
    next_sleep_cnt = sleep_cnt;
    case (state)
      SBSC_ST_RUN: begin
        if (sleep_request) begin
          next_state = SBSC_ST_ENTER;
          next_sleep_cnt = SBSC_SLEEP_LOAD;
        end
      end
      SBSC_ST_ENTER: begin
        if (!sleep_request) begin
          next_state = SBSC_ST_EXIT;
          next_sleep_cnt = SBSC_SLEEP_LOAD;
        end else if (sleep_cnt == SBSC_CNT_ZERO) begin
          next_state = SBSC_ST_SLEEP;
        end else begin
          next_sleep_cnt = 2'(sleep_cnt - SBSC_CNT_ONE);
        end
      end
      SBSC_ST_SLEEP: begin
        if (!sleep_request) begin
          next_state = SBSC_ST_EXIT;
          next_sleep_cnt = SBSC_SLEEP_LOAD;
        end
      end
      SBSC_ST_EXIT: begin
        if (sleep_request) begin
          next_state = SBSC_ST_ENTER;
          next_sleep_cnt = SBSC_SLEEP_LOAD;
        end else if (sleep_cnt == SBSC_CNT_ZERO) begin
          next_state = SBSC_ST_RUN;
        end else begin
          next_sleep_cnt = 2'(sleep_cnt - SBSC_CNT_ONE);
        end
      end
      default: begin
        next_state = SBSC_ST_RUN;
        next_sleep_cnt = SBSC_CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= SBSC_ST_RUN;
      sleep_cnt <= SBSC_CNT_ZERO;
    end else begin
      state <= next_state;
      sleep_cnt <= next_sleep_cnt;
    end
  end

  // pending burst is dropped on sleep; no recovery of it is promised
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      active <= 1'b0;
      cyc_read <= 1'b0;
      power_down <= 1'b1;
      hi_addr <= '0;
    end else begin
      cyc_read <= do_read;
      if (do_begin) begin
        hi_addr <= addr[ADDR_W-1:2];
      end
      if (!run) begin
        active <= 1'b0;
      end else if (do_begin) begin
        active <= 1'b1;
      end else if (do_desel) begin
        active <= 1'b0;
      end
      if (state != SBSC_ST_RUN) begin
        power_down <= 1'b1;
      end else if (do_desel) begin
        power_down <= 1'b1;
      end else if (do_begin) begin
        power_down <= 1'b0;
      end
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_sleep_in;
    (state == SBSC_ST_RUN && sleep_request) ##1 sleep_request [*2];
  endsequence
  sequence seq_sleep_out;
    (state == SBSC_ST_SLEEP && !sleep_request) ##1 !sleep_request [*2];
  endsequence

  sleep_float_a: assert property (sleep_request |-> dq_oe == '0)
    else $error("data driven while sleep requested");
  proc_read_a: assert property (run && sel_all && !proc_addr_strobe_n |=> cyc_read)
    else $error("processor start did not read");
  ctrl_write_a: assert property (run && sel_all && proc_addr_strobe_n
    && !ctrl_addr_strobe_n && !write_dec_n |=> !cyc_read && active)
    else $error("controller start with write decode did not write");
  burst_next_a: assert property (do_cont && !burst_step_n |=>
    burst.cur_addr == $past(burst.next_addr))
    else $error("continue did not move to the next burst address");
  burst_hold_a: assert property (do_cont && burst_step_n |=> $stable(burst.cur_addr))
    else $error("suspend changed the burst address");
  global_write_a: assert property (!global_write_n |-> &lane_wr)
    else $error("global write did not enable all lanes");
  proc_nowrite_a: assert property (run && proc_go |-> !do_write)
    else $error("write on processor start cycle");
  write_mask_a: assert property (do_write |=> dq_oe == '0)
    else $error("data driven during write");
  read_drive_a: assert property (do_read ##1 !out_enable_n && !sleep_request
    |-> &dq_oe)
    else $error("read with output enable low did not drive");
  desel_a: assert property (do_desel |=> power_down && !cyc_read)
    else $error("deselect did not power down");
  sleep_in_a: assert property (seq_sleep_in |=> state == SBSC_ST_SLEEP)
    else $error("sleep not entered after two cycles");
  sleep_out_a: assert property (seq_sleep_out |=> state == SBSC_ST_RUN)
    else $error("sleep not left after two cycles");
endmodule

// ===== rtl/sbsc_pkg.sv
// Purpose: shared constants and types of the burst sram cycle control
// Assumes: one clock, synchronous active-low reset
// Notes: sleep entry and exit counts are in clock cycles
package sbsc_pkg;
  localparam int SBSC_ADDR_W = 19;
  localparam int SBSC_LANES = 4;
  localparam int SBSC_LANE_W = 8;
  localparam int SBSC_SLEEP_CYC = 2;
  localparam logic [1:0] SBSC_SLEEP_LOAD = 2'(SBSC_SLEEP_CYC - 1);
  localparam logic [1:0] SBSC_CNT_ZERO = 2'h0;
  localparam logic [1:0] SBSC_CNT_ONE = 2'h1;
  localparam logic SBSC_ORDER_RST = 1'b1;

  typedef enum logic [3:0] {
    SBSC_ST_RUN = 4'h1,
    SBSC_ST_ENTER = 4'h2,
    SBSC_ST_SLEEP = 4'h4,
    SBSC_ST_EXIT = 4'h8
  } sbsc_state_t;
endpackage

// ===== rtl/sbsc_burst_if.sv
// Purpose: link between the cycle control and its burst counter
// Assumes: both ends on ref_clk
// Notes: next_addr is the address the counter holds after one step
`timescale 1ns/100ps
interface sbsc_burst_if;
  logic load;
  logic step;
  logic interleave;
  logic [1:0] base_addr;
  logic [1:0] cur_addr;
  logic [1:0] next_addr;
  modport ctr (input load, input step, input interleave, input base_addr,
    output cur_addr, output next_addr);
  modport ctl (output load, output step, output interleave, output base_addr,
    input cur_addr, input next_addr);
endinterface

// ===== rtl/sbsc_burst_ctr.sv
// Purpose: two-bit wrapping burst counter, linear or interleaved
// Assumes: load and step never both high
// Notes: order is captured with the start address
`timescale 1ns/100ps
module sbsc_burst_ctr
  import sbsc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control side
  sbsc_burst_if.ctr bus
);
  logic [1:0] base;
  logic [1:0] cnt;
  logic ilv;
  logic [1:0] cnt_inc;

  assign cnt_inc = 2'(cnt + SBSC_CNT_ONE);
  // interleaved order is xor with the count, linear is a wrapping sum
  assign bus.cur_addr = ilv ? (base ^ cnt) : 2'(base + cnt);
  assign bus.next_addr = ilv ? (base ^ cnt_inc) : 2'(base + cnt_inc);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      base <= SBSC_CNT_ZERO;
      cnt <= SBSC_CNT_ZERO;
      ilv <= SBSC_ORDER_RST;
    end else if (bus.load) begin
      base <= bus.base_addr;
      cnt <= SBSC_CNT_ZERO;
      ilv <= bus.interleave;
    end else if (bus.step) begin
      cnt <= cnt_inc;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  load_start_a: assert property (bus.load |=> bus.cur_addr == $past(bus.base_addr))
    else $error("burst counter did not load the start address");
  wrap_four_a: assert property ((bus.step && !bus.load) [*4] |=>
    bus.cur_addr == $past(bus.cur_addr, 4))
    else $error("burst counter did not wrap after four steps");
endmodule

// ===== verification/sbsc_master_model.sv
// Purpose: processor side of the memory bus, resolves the shared data and parity wires
// Assumes: one drive enable per data and parity bit on the device side
// Notes: parity of a lane is taken from that lane's low data bit
`timescale 1ns/100ps
module sbsc_master_model (
  // clock
  input wire logic ref_clk,
  // device side
  input wire logic [31:0] dq_out,
  input wire logic [31:0] dq_oe,
  input wire logic [3:0] parity_io_out,
  input wire logic [3:0] parity_io_oe,
  // master side
  input wire logic mst_en,
  input wire logic [31:0] mst_d,
  // resolved wires
  output logic [31:0] dq_wire,
  output logic [3:0] par_wire
);
  logic [35:0] last = 36'h0_0000_0000;
  logic [35:0] dev_oe;
  logic [35:0] dev_d;
  logic [35:0] mst_w;
  logic [35:0] bus;
  assign dev_oe = {parity_io_oe, dq_oe};
  assign dev_d = {parity_io_out, dq_out};
  assign mst_w = {mst_d[24], mst_d[16], mst_d[8], mst_d[0], mst_d};
  // a floating bit shows the inverse of its last value, so it never reads as good data
  assign bus = (dev_oe & dev_d) | (~dev_oe & (mst_en ? mst_w : ~last));
  assign dq_wire = bus[31:0];
  assign par_wire = bus[35:32];
  always @(posedge ref_clk) begin
    last <= bus;
  end
endmodule

// ===== verification/sync_burst_sram_cycle_ctrl_bench.sv
// Purpose: self-checking bench of the burst sram cycle control
// Assumes: inputs change at the falling edge, ADDR_W reduced to 4
// Notes: table rows run back to back; sleep and async enable are tested by hand
`timescale 1ns/100ps
module sync_burst_sram_cycle_ctrl_bench;
  import sbsc_pkg::*;
  // c = {proc strobe, ctrl strobe, step, order, oe, global write, byte enable}
  // f = {master drives data, read expected, power down expected}
  typedef struct packed {
    logic [2:0] sel;
    logic [6:0] c;
    logic [3:0] bs;
    logic [3:0] a;
    logic [2:0] f;
    logic [31:0] d;
  } sbsc_row_t;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic chip_sel_pipe_n, chip_sel_hi, chip_sel_lo_n, sleep_request, proc_addr_strobe_n;
  logic ctrl_addr_strobe_n, burst_step_n, burst_order, global_write_n, byte_write_enable_n;
  logic out_enable_n, mst_en, power_down;
  logic [3:0] addr, byte_select_n, parity_io_in, parity_io_out, parity_io_oe;
  logic [31:0] dq_in, dq_out, dq_oe, mst_d;
  int fail_count = 0;
  int samples_checked = 0;
  sbsc_row_t rows [0:15] = '{
    '{3'b010, 7'b1010101, 4'hF, 4'h0, 3'b100, 32'h1100_0011},
    '{3'b010, 7'b1100001, 4'hF, 4'h0, 3'b100, 32'h0011_2233},
    '{3'b010, 7'b1100001, 4'hF, 4'h0, 3'b100, 32'h2222_2222},
    '{3'b010, 7'b1100001, 4'hF, 4'h0, 3'b100, 32'h3333_3333},
    '{3'b010, 7'b0010000, 4'h0, 4'h1, 3'b010, 32'h0011_2233},
    '{3'b110, 7'b0100011, 4'hF, 4'h0, 3'b010, 32'h2222_2222},
    '{3'b010, 7'b1110011, 4'hF, 4'h0, 3'b010, 32'h2222_2222},
    '{3'b010, 7'b1100011, 4'hF, 4'h0, 3'b010, 32'h3333_3333},
    '{3'b010, 7'b1100011, 4'hF, 4'h0, 3'b010, 32'h1100_0011},
    '{3'b010, 7'b1011011, 4'hF, 4'h1, 3'b010, 32'h0011_2233},
    '{3'b010, 7'b1101011, 4'hF, 4'h0, 3'b010, 32'h1100_0011},
    '{3'b010, 7'b1011110, 4'hA, 4'h2, 3'b100, 32'hFFFF_FFFF},
    '{3'b010, 7'b1101010, 4'hF, 4'h0, 3'b010, 32'h3333_3333},
    '{3'b010, 7'b1011011, 4'hF, 4'h2, 3'b010, 32'h22FF_22FF},
    '{3'b110, 7'b1011011, 4'hF, 4'h2, 3'b001, 32'h0000_0000},
    '{3'b001, 7'b1101011, 4'hF, 4'h0, 3'b001, 32'h0000_0000}};
  // processor start, continue write, reads up to the wrap, then read back the write
  sbsc_row_t wrap_rows [0:5] = '{
    '{3'b010, 7'b0110011, 4'hF, 4'h0, 3'b010, 32'h1100_0011},
    '{3'b010, 7'b1100101, 4'hF, 4'h0, 3'b100, 32'h4545_4545},
    '{3'b010, 7'b1100011, 4'hF, 4'h0, 3'b010, 32'h22FF_22FF},
    '{3'b010, 7'b1100011, 4'hF, 4'h0, 3'b010, 32'h3333_3333},
    '{3'b010, 7'b1100011, 4'hF, 4'h0, 3'b010, 32'h1100_0011},
    '{3'b010, 7'b1010011, 4'hF, 4'h1, 3'b010, 32'h4545_4545}};
  always #5 ref_clk = ~ref_clk;
  sbsc_cycle_ctrl #(.ADDR_W(4)) dut (.ref_clk, .rst_n, .chip_sel_pipe_n, .chip_sel_hi,
    .chip_sel_lo_n, .sleep_request, .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_step_n,
    .burst_order, .addr, .global_write_n, .byte_write_enable_n, .byte_select_n,
    .out_enable_n, .dq_in, .dq_out, .dq_oe, .parity_io_in, .parity_io_out, .parity_io_oe,
    .power_down);
  sbsc_master_model bus_master (.ref_clk, .dq_out, .dq_oe, .parity_io_out, .parity_io_oe,
    .mst_en, .mst_d, .dq_wire(dq_in), .par_wire(parity_io_in));
  function automatic logic [3:0] par(input logic [31:0] d);
    return {d[24], d[16], d[8], d[0]};
  endfunction
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic drive(input sbsc_row_t r);
    {chip_sel_pipe_n, chip_sel_hi, chip_sel_lo_n} = r.sel;
    {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n, burst_order} = r.c[6:3];
    {out_enable_n, global_write_n, byte_write_enable_n} = r.c[2:0];
    byte_select_n = r.bs;
    addr = r.a;
    mst_en = r.f[2];
    mst_d = r.d;
  endtask
  task automatic check_row(input sbsc_row_t r);
    if (r.f[1]) begin
      check({parity_io_out, dq_out}, {par(r.d), r.d});
      check({parity_io_oe, dq_oe}, 36'hF_FFFF_FFFF);
    end else begin
      check({parity_io_oe, dq_oe}, 36'h0_0000_0000);
    end
    check(36'(power_down), 36'(r.f[0]));
  endtask
  initial begin
    sleep_request = 1'b0;
    drive(rows[15]);
    repeat (16) @(negedge ref_clk);
    check({parity_io_oe, dq_oe}, 36'h0_0000_0000);
    check(36'(power_down), 36'h0_0000_0001);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      drive(rows[i]);
      @(negedge ref_clk);
      check_row(rows[i]);
    end
    // output enable has to act inside the cycle, with no clock edge
    drive(rows[13]);
    @(negedge ref_clk);
    check_row(rows[13]);
    #2 out_enable_n = 1'b1;
    #1 check({parity_io_oe, dq_oe}, 36'h0_0000_0000);
    out_enable_n = 1'b0;
    #1 check({parity_io_oe, dq_oe}, 36'hF_FFFF_FFFF);
    @(negedge ref_clk);
    drive(rows[14]);
    @(negedge ref_clk);
    sleep_request = 1'b1;
    drive(rows[9]);
    repeat (4) begin
      @(negedge ref_clk);
      check({parity_io_oe, dq_oe}, 36'h0_0000_0000);
      check(36'(power_down), 36'h0_0000_0001);
    end
    check({parity_io_out, dq_out}, {par(32'h22FF_22FF), 32'h22FF_22FF});
    sleep_request = 1'b0;
    drive(rows[15]);
    // one edge still in sleep, then two in the exit state before requests count
    repeat (3) @(negedge ref_clk);
    drive(rows[9]);
    @(negedge ref_clk);
    check_row(rows[9]);
    foreach (wrap_rows[i]) begin
      drive(wrap_rows[i]);
      @(negedge ref_clk);
      check_row(wrap_rows[i]);
    end
    stop_test;
  end
  initial begin
    #200us;
    fail_count++;
    stop_test;
  end
endmodule
